// ===== core/low_power_mode_controller.sv
// low-power mode controller: mode sequencing, module gating, clock choice, apb registers
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "lpc_map.svh"
module low_power_mode_controller (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core handshake
    input wire logic cpu_wait_req,
    output logic cpu_halt,
    output logic irq_exception_req,
    // asynchronous wake and reset sources
    input wire logic [`LPC_NUM_WAKE-1:0] wake_src,
    input wire logic [`LPC_NUM_RST-1:0] reset_src,
    // module gating
    input wire logic [`LPC_NUM_MOD-1:0] module_ctrl_en,
    output logic [`LPC_NUM_MOD-1:0] module_run,
    output logic io_hold,
    // mode, clock and interrupt status
    output logic [1:0] lp_mode,
    output logic [2:0] clk_src_sel,
    output logic in_reset,
    output logic irq
);
    lpc_sync_if sync_bus ();
    lpc_pkg::lpc_state_t state_ff, nxt_state;
    lpc_pkg::lp_mode_t mode_ff, target_mode;
    lpc_pkg::clk_src_t clk_src_ff;
    logic [1:0] ctrl_mode_ff;
    logic soft_rst_ff;
    logic [3:0] retclk_ff;
    logic [2:0] cnt_ff;
    logic [`LPC_NUM_EV-1:0] isr_ff, imr_ff, events;
    logic [`LPC_NUM_MOD-1:0] run_ff, stop_mask, run_mask;
    logic [`LPC_NUM_WAKE-1:0] wake_lvl;
    logic [`LPC_NUM_RST-1:0] rst_lvl;
    logic wake_any, rst_any, entry_done;
    logic halt_ff, exc_ff, io_hold_ff, irq_ff, in_reset_ff;
    logic pready_ff, pslverr_ff;
    logic [31:0] prdata_ff, rd_mux;
    logic rd_hit, wr_en;
    localparam logic [`LPC_NUM_MOD-1:0] RUN_RST = `LPC_RUN_NORMAL;

    assign sync_bus.raw = {reset_src, wake_src};
    lpc_pin_sync u_sync (
        .clk(clk),
        .srst(srst),
        .pins(sync_bus.sync)
    );
    assign wake_lvl = sync_bus.clean[`LPC_NUM_WAKE-1:0];
    assign rst_lvl = sync_bus.clean[`LPC_NUM_SYNC-1:`LPC_NUM_WAKE];

    assign wake_any = |wake_lvl;
    assign rst_any = (|rst_lvl) | soft_rst_ff;
    assign entry_done = (cnt_ff == `LPC_ENTRY_LAST);
    // a mode field of zero also selects sleep
    assign target_mode = (ctrl_mode_ff == 2'h0) ? lpc_pkg::MODE_SLEEP : lpc_pkg::lp_mode_t'(ctrl_mode_ff);

    // mode sequencing
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            lpc_pkg::ST_RESET: begin
                if (!rst_any) begin
                    nxt_state = lpc_pkg::ST_NORMAL;
                end
            end
            lpc_pkg::ST_NORMAL: begin
                if (cpu_wait_req) begin
                    nxt_state = lpc_pkg::ST_ENTRY;
                end
            end
            lpc_pkg::ST_ENTRY: begin
                if (wake_any) begin
                    nxt_state = lpc_pkg::ST_NORMAL;
                end else if (entry_done) begin
                    nxt_state = lpc_pkg::ST_LOWPWR;
                end
            end
            lpc_pkg::ST_LOWPWR: begin
                if (wake_any) begin
                    nxt_state = lpc_pkg::ST_NORMAL;
                end
            end
            default: begin
                nxt_state = lpc_pkg::ST_RESET;
            end
        endcase
        if (rst_any) begin
            nxt_state = lpc_pkg::ST_RESET;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= lpc_pkg::ST_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || state_ff != lpc_pkg::ST_ENTRY) begin
            cnt_ff <= 3'h0;
        end else begin
            cnt_ff <= cnt_ff + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || rst_any) begin
            mode_ff <= lpc_pkg::MODE_NORMAL;
        end else if (state_ff == lpc_pkg::ST_ENTRY && nxt_state == lpc_pkg::ST_LOWPWR) begin
            mode_ff <= target_mode;
        end else if (nxt_state == lpc_pkg::ST_NORMAL) begin
            mode_ff <= lpc_pkg::MODE_NORMAL;
        end
    end

    // core halt from the start of entry, exception pulse on an aborted entry
    always_ff @(posedge clk) begin
        if (srst) begin
            halt_ff <= 1'b1;
            exc_ff <= 1'b0;
            in_reset_ff <= 1'b1;
        end else begin
            halt_ff <= (nxt_state != lpc_pkg::ST_NORMAL);
            exc_ff <= (state_ff == lpc_pkg::ST_ENTRY) && wake_any && !rst_any;
            in_reset_ff <= (nxt_state == lpc_pkg::ST_RESET);
        end
    end

    // system clock source
    always_ff @(posedge clk) begin
        if (srst || rst_any) begin
            clk_src_ff <= lpc_pkg::CLK_LOW_SPEED_ONCHIP_OSC;
        end else if (state_ff == lpc_pkg::ST_LOWPWR && wake_any) begin
            if (mode_ff == lpc_pkg::MODE_SLEEP && retclk_ff[`LPC_RETCLK_EN]) begin
                clk_src_ff <= lpc_pkg::clk_src_t'(retclk_ff[`LPC_RETCLK_SRC]);
            end
            // deep sleep and standby keep the source unchanged
        end else if (wr_en && paddr == `LPC_OFF_CLKSEL && state_ff == lpc_pkg::ST_NORMAL) begin
            clk_src_ff <= lpc_pkg::clk_src_t'(pwdata[`LPC_CLKSEL_SRC]);
        end
    end

    // gating profile of the current mode
    always_comb begin
        case (mode_ff)
            lpc_pkg::MODE_SLEEP: begin
                stop_mask = `LPC_STOP_SLEEP;
                run_mask = `LPC_RUN_SLEEP;
            end
            lpc_pkg::MODE_DEEP: begin
                stop_mask = `LPC_STOP_DEEP;
                run_mask = `LPC_RUN_DEEP;
            end
            lpc_pkg::MODE_STANDBY: begin
                stop_mask = `LPC_STOP_STANDBY;
                run_mask = `LPC_RUN_STANDBY;
            end
            default: begin
                stop_mask = `LPC_STOP_NORMAL;
                run_mask = `LPC_RUN_NORMAL;
            end
        endcase
    end

    // run enables gate clocks only, so stopped modules keep their registers
    genvar m;
    generate
        for (m = 0; m < `LPC_NUM_MOD; m++) begin : g_mod
            always_ff @(posedge clk) begin
                if (srst) begin
                    run_ff[m] <= RUN_RST[m];
                end else if (stop_mask[m]) begin
                    run_ff[m] <= 1'b0;
                end else if (run_mask[m]) begin
                    run_ff[m] <= 1'b1;
                end else begin
                    run_ff[m] <= module_ctrl_en[m];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            io_hold_ff <= 1'b0;
        end else begin
            io_hold_ff <= (mode_ff == lpc_pkg::MODE_STANDBY);
        end
    end

    // apb registers
    assign wr_en = psel && penable && pready_ff && pwrite;

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_mode_ff <= `LPC_RST_CTRL;
            retclk_ff <= `LPC_RST_RETCLK;
            imr_ff <= `LPC_RST_IMR;
            soft_rst_ff <= 1'b0;
        end else begin
            soft_rst_ff <= wr_en && paddr == `LPC_OFF_CTRL && pwdata[`LPC_CTRL_SOFT_RST];
            if (wr_en && paddr == `LPC_OFF_CTRL) begin
                ctrl_mode_ff <= pwdata[`LPC_CTRL_MODE];
            end
            if (wr_en && paddr == `LPC_OFF_RETCLK) begin
                retclk_ff <= pwdata[3:0];
            end
            if (wr_en && paddr == `LPC_OFF_IMR) begin
                imr_ff <= pwdata[`LPC_NUM_EV-1:0];
            end
        end
    end

    // sticky events: a new event wins over a write-one clear in the same cycle
    always_comb begin
        events = '0;
        events[`LPC_EV_WAKE] = (state_ff == lpc_pkg::ST_LOWPWR) && wake_any && !rst_any;
        events[`LPC_EV_ABORT] = (state_ff == lpc_pkg::ST_ENTRY) && wake_any && !rst_any;
        events[`LPC_EV_ENTER] = (state_ff == lpc_pkg::ST_ENTRY) && entry_done && !wake_any && !rst_any;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            isr_ff <= '0;
        end else if (wr_en && paddr == `LPC_OFF_ISR) begin
            isr_ff <= (isr_ff & ~pwdata[`LPC_NUM_EV-1:0]) | events;
        end else begin
            isr_ff <= isr_ff | events;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(isr_ff & imr_ff);
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            `LPC_OFF_CTRL: rd_mux[1:0] = ctrl_mode_ff;
            `LPC_OFF_RETCLK: rd_mux[3:0] = retclk_ff;
            `LPC_OFF_CLKSEL: rd_mux[2:0] = clk_src_ff;
            `LPC_OFF_STATUS: rd_mux[8:0] = {state_ff, halt_ff, clk_src_ff, mode_ff};
            `LPC_OFF_ISR: rd_mux[`LPC_NUM_EV-1:0] = isr_ff;
            `LPC_OFF_IMR: rd_mux[`LPC_NUM_EV-1:0] = imr_ff;
            default: rd_hit = 1'b0;
        endcase
    end

    // one access cycle: answer prepared in the setup cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable) begin
            pready_ff <= 1'b1;
            pslverr_ff <= !rd_hit;
            prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
        end else begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign cpu_halt = halt_ff;
    assign irq_exception_req = exc_ff;
    assign module_run = run_ff;
    assign io_hold = io_hold_ff;
    assign lp_mode = mode_ff;
    assign clk_src_sel = clk_src_ff;
    assign in_reset = in_reset_ff;
    assign irq = irq_ff;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_entry_wake;
        state_ff == lpc_pkg::ST_ENTRY && wake_any && !rst_any;
    endsequence
    sequence s_sleep_wake;
        state_ff == lpc_pkg::ST_LOWPWR && mode_ff == lpc_pkg::MODE_SLEEP && wake_any && !rst_any;
    endsequence
    sequence s_deep_wake;
        state_ff == lpc_pkg::ST_LOWPWR && mode_ff != lpc_pkg::MODE_SLEEP && wake_any && !rst_any;
    endsequence

    property p_halt_lowpwr;
        state_ff == lpc_pkg::ST_LOWPWR |-> halt_ff && mode_ff != lpc_pkg::MODE_NORMAL;
    endproperty
    a_halt_lowpwr: assert property (p_halt_lowpwr) else $error("core not halted in low-power mode");

    property p_three_modes;
        (state_ff == lpc_pkg::ST_ENTRY && entry_done && !wake_any && !rst_any) |=> mode_ff == $past(target_mode);
    endproperty
    a_three_modes: assert property (p_three_modes) else $error("entered mode differs from selection");

    property p_periph_follow;
        (mode_ff == lpc_pkg::MODE_SLEEP && $stable(mode_ff))
            |-> run_ff[`LPC_M_PERIPH] == $past(module_ctrl_en[`LPC_M_PERIPH]);
    endproperty
    a_periph_follow: assert property (p_periph_follow) else $error("peripheral not under own control in sleep");

    property p_standby_gate;
        (mode_ff == lpc_pkg::MODE_STANDBY && $stable(mode_ff)) |-> !run_ff[`LPC_M_PERIPH] && !run_ff[0] && io_hold_ff;
    endproperty
    a_standby_gate: assert property (p_standby_gate) else $error("standby gating wrong");

    property p_ram_stop;
        (mode_ff inside {lpc_pkg::MODE_DEEP, lpc_pkg::MODE_STANDBY} && $stable(mode_ff)) |-> !run_ff[`LPC_M_RAM];
    endproperty
    a_ram_stop: assert property (p_ram_stop) else $error("ram running in deep mode");

    property p_independent_watchdog_own;
        !$past(srst) |-> run_ff[`LPC_M_INDEPENDENT_WATCHDOG] == $past(module_ctrl_en[`LPC_M_INDEPENDENT_WATCHDOG]);
    endproperty
    a_independent_watchdog_own: assert property (p_independent_watchdog_own) else $error("independent watchdog forced");

    property p_abort;
        s_entry_wake |=> state_ff == lpc_pkg::ST_NORMAL && exc_ff ##1 !exc_ff;
    endproperty
    a_abort: assert property (p_abort) else $error("entry not aborted on wake");

    property p_sleep_exit;
        s_sleep_wake ##0 retclk_ff[`LPC_RETCLK_EN]
            |=> state_ff == lpc_pkg::ST_NORMAL && clk_src_ff == $past(retclk_ff[`LPC_RETCLK_SRC]);
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit clock wrong");

    property p_deep_exit;
        s_deep_wake |=> state_ff == lpc_pkg::ST_NORMAL && $stable(clk_src_ff) ##1 !halt_ff;
    endproperty
    a_deep_exit: assert property (p_deep_exit) else $error("deep exit changed clock");

    property p_reset_any;
        rst_any |=> state_ff == lpc_pkg::ST_RESET && in_reset_ff;
    endproperty
    a_reset_any: assert property (p_reset_any) else $error("reset source ignored");

    property p_reset_exit;
        (state_ff == lpc_pkg::ST_RESET && !rst_any) |=> state_ff == lpc_pkg::ST_NORMAL && clk_src_ff == lpc_pkg::CLK_LOW_SPEED_ONCHIP_OSC;
    endproperty
    a_reset_exit: assert property (p_reset_exit) else $error("reset exit not normal on low-speed clock");

    property p_flash_wdt;
        $stable(mode_ff) |-> run_ff[`LPC_M_POR]
            && (mode_ff == lpc_pkg::MODE_NORMAL || !run_ff[`LPC_M_WDT])
            && (run_ff[`LPC_M_FLASH] == (mode_ff inside {lpc_pkg::MODE_NORMAL, lpc_pkg::MODE_SLEEP}));
    endproperty
    a_flash_wdt: assert property (p_flash_wdt) else $error("flash, watchdog or por gating wrong");
endmodule
`default_nettype wire

// ===== core/lpc_map.svh
// offsets, field positions, reset values and gating profiles of the low-power controller
`ifndef LPC_MAP_SVH
`define LPC_MAP_SVH

// register byte offsets
`define LPC_OFF_CTRL 12'h000
`define LPC_OFF_RETCLK 12'h004
`define LPC_OFF_CLKSEL 12'h008
`define LPC_OFF_STATUS 12'h00c
`define LPC_OFF_ISR 12'h010
`define LPC_OFF_IMR 12'h014

// field positions
`define LPC_CTRL_MODE 1:0
`define LPC_CTRL_SOFT_RST 8
`define LPC_RETCLK_EN 0
`define LPC_RETCLK_SRC 3:1
`define LPC_CLKSEL_SRC 2:0
`define LPC_EV_WAKE 0
`define LPC_EV_ABORT 1
`define LPC_EV_ENTER 2

// reset values
`define LPC_RST_CTRL 2'h0
`define LPC_RST_RETCLK 4'h0
`define LPC_RST_IMR 3'h0

// sizes and timing
`define LPC_NUM_MOD 16
`define LPC_NUM_WAKE 16
`define LPC_NUM_RST 5
`define LPC_NUM_SYNC 21
`define LPC_NUM_EV 3
`define LPC_ENTRY_LAST 3'h3

// module indices in the gating vector
`define LPC_M_RAM 7
`define LPC_M_FLASH 8
`define LPC_M_WDT 9
`define LPC_M_INDEPENDENT_WATCHDOG 10
`define LPC_M_POR 14
`define LPC_M_PERIPH 15

// per-mode profiles: forced stop and forced run, the rest follow their own control
`define LPC_STOP_NORMAL 16'h0000
`define LPC_RUN_NORMAL 16'h4100
`define LPC_STOP_SLEEP 16'h0200
`define LPC_RUN_SLEEP 16'h4100
`define LPC_STOP_DEEP 16'h0380
`define LPC_RUN_DEEP 16'h4000
`define LPC_STOP_STANDBY 16'h83e5
`define LPC_RUN_STANDBY 16'h4000
`define LPC_ALWAYS_CTRL 16'h3c1a

`endif

// ===== core/lpc_pkg.sv
// types shared by the low-power controller files
`default_nettype none
package lpc_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_SLEEP = 2'h1,
        MODE_DEEP = 2'h2,
        MODE_STANDBY = 2'h3
    } lp_mode_t;

    typedef enum logic [2:0] {
        CLK_LOW_SPEED_ONCHIP_OSC = 3'h0,
        CLK_HOCO = 3'h1,
        CLK_MAIN = 3'h2,
        CLK_SUB = 3'h3,
        CLK_PLL = 3'h4
    } clk_src_t;

    typedef enum logic [2:0] {
        ST_RESET = 3'h0,
        ST_NORMAL = 3'h1,
        ST_ENTRY = 3'h3,
        ST_LOWPWR = 3'h2
    } lpc_state_t;
endpackage
`default_nettype wire

// ===== core/lpc_sync_if.sv
// carrier between the pin synchroniser and the controller
`timescale 1ns/100ps
`default_nettype none
`include "lpc_map.svh"
interface lpc_sync_if;
    logic [`LPC_NUM_SYNC-1:0] raw;
    logic [`LPC_NUM_SYNC-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface
`default_nettype wire

// ===== core/lpc_pin_sync.sv
// three-stage synchroniser for asynchronous wake and reset pins
`timescale 1ns/100ps
`default_nettype none
`include "lpc_map.svh"
module lpc_pin_sync (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // pins in, settled levels out
    lpc_sync_if.sync pins
);
    logic [`LPC_NUM_SYNC-1:0] s1_ff;
    logic [`LPC_NUM_SYNC-1:0] s2_ff;
    logic [`LPC_NUM_SYNC-1:0] s3_ff;
    logic [`LPC_NUM_SYNC-1:0] clean_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= pins.raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // a level counts once the second and third stage agree
    genvar i;
    generate
        for (i = 0; i < `LPC_NUM_SYNC; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (srst) begin
                    clean_ff[i] <= 1'b0;
                end else if (s2_ff[i] == s3_ff[i]) begin
                    clean_ff[i] <= s3_ff[i];
                end
            end
        end
    endgenerate

    assign pins.clean = clean_ff;
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the low-power mode controller, driven over apb and its pins
`timescale 1ns/100ps
`default_nettype none
`include "lpc_map.svh"
module testbench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cpu_wait_req = 1'b0;
    logic cpu_halt;
    logic irq_exception_req;
    logic [`LPC_NUM_WAKE-1:0] wake_src = '0;
    logic [`LPC_NUM_RST-1:0] reset_src = '0;
    logic [`LPC_NUM_MOD-1:0] module_ctrl_en = '1;
    logic [`LPC_NUM_MOD-1:0] module_run;
    logic io_hold;
    logic [1:0] lp_mode;
    logic [2:0] clk_src_sel;
    logic in_reset;
    logic irq;
    int error_cnt = 0;
    int total_checks = 0;
    logic [31:0] rd;
    logic err;
    int order [3] = '{2, 3, 1};

    always #4 clk = ~clk;

    low_power_mode_controller i_low_power_mode_controller (
        .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_wait_req(cpu_wait_req), .cpu_halt(cpu_halt), .irq_exception_req(irq_exception_req),
        .wake_src(wake_src), .reset_src(reset_src), .module_ctrl_en(module_ctrl_en),
        .module_run(module_run), .io_hold(io_hold), .lp_mode(lp_mode), .clk_src_sel(clk_src_sel),
        .in_reset(in_reset), .irq(irq)
    );

    task automatic complete_run();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; read data and error are taken at the edge where pready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check("pready", {31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wait_mode(input logic [1:0] m);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (lp_mode !== m && n < 40);
        check("lp_mode", {30'h0, lp_mode}, {30'h0, m});
    endtask

    task automatic wait_reset(input logic v);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (in_reset !== v && n < 16);
        check("in_reset", {31'h0, in_reset}, {31'h0, v});
    endtask

    task automatic enter(input logic [1:0] m);
        apb(1'b1, `LPC_OFF_CTRL, {30'h0, m});
        @(posedge clk);
        cpu_wait_req <= 1'b1;
        @(posedge clk);
        cpu_wait_req <= 1'b0;
        @(posedge clk);
        check("cpu_halt", {31'h0, cpu_halt}, 32'h1);
        // a mode field of zero selects sleep as well
        wait_mode((m == 2'h0) ? 2'h1 : m);
    endtask

    task automatic wake(input int idx);
        wake_src[idx] <= 1'b1;
        wait_mode(2'h0);
        wake_src[idx] <= 1'b0;
        cycles(8);
        check("cpu_halt", {31'h0, cpu_halt}, 32'h0);
    endtask

    // forced stop and forced run of each mode, low half stop, high half run
    function automatic logic [31:0] profile(input int m);
        case (m)
            1: profile = {`LPC_RUN_SLEEP, `LPC_STOP_SLEEP};
            2: profile = {`LPC_RUN_DEEP, `LPC_STOP_DEEP};
            3: profile = {`LPC_RUN_STANDBY, `LPC_STOP_STANDBY};
            default: profile = {`LPC_RUN_NORMAL, `LPC_STOP_NORMAL};
        endcase
    endfunction

    initial begin
        #(8 * 20000);
        error_cnt++;
        complete_run();
    end

    initial begin
        int m;
        logic [31:0] p;
        logic pulse_seen;
        logic left_normal;
        repeat (16) @(posedge clk);
        check("in_reset", {31'h0, in_reset}, 32'h1);
        srst <= 1'b0;
        cycles(3);
        check("lp_mode", {30'h0, lp_mode}, 32'h0);
        check("clk_src_sel", {29'h0, clk_src_sel}, 32'h0);
        check("cpu_halt", {31'h0, cpu_halt}, 32'h0);
        apb(1'b0, `LPC_OFF_CTRL, 32'h0);
        check("ctrl reset", rd, 32'h0);
        apb(1'b0, `LPC_OFF_RETCLK, 32'h0);
        check("retclk reset", rd, 32'h0);
        apb(1'b0, `LPC_OFF_IMR, 32'h0);
        check("imr reset", rd, 32'h0);
        apb(1'b0, `LPC_OFF_STATUS, 32'h0);
        check("status reset", rd, 32'h40);
        apb(1'b0, 12'h018, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(1'b1, `LPC_OFF_CLKSEL, {29'h0, lpc_pkg::CLK_HOCO});
        apb(1'b1, `LPC_OFF_RETCLK, {28'h0, lpc_pkg::CLK_PLL, 1'b1});
        // deep and standby first so the sleep exit is the only clock switch
        for (int k = 0; k < 3; k++) begin
            m = order[k];
            p = profile(m);
            enter(m[1:0]);
            cycles(3);
            check("module_run own", {16'h0, module_run}, {16'h0, ~p[15:0] | p[31:16]});
            check("io_hold", {31'h0, io_hold}, {31'h0, m == 3});
            check("ram run", {31'h0, module_run[`LPC_M_RAM]}, {31'h0, m == 1});
            check("por run", {31'h0, module_run[`LPC_M_POR]}, 32'h1);
            check("flash run", {31'h0, module_run[`LPC_M_FLASH]}, {31'h0, m == 1});
            module_ctrl_en <= '0;
            cycles(3);
            check("module_run off", {16'h0, module_run}, {16'h0, p[31:16]});
            check("ram off", {31'h0, module_run[`LPC_M_RAM]}, 32'h0);
            module_ctrl_en <= 16'h3c1a;
            cycles(3);
            check("always domain", {16'h0, module_run & 16'h3c1a}, 32'h3c1a);
            module_ctrl_en <= '1;
            apb(1'b0, `LPC_OFF_STATUS, 32'h0);
            check("status low power", rd, 32'ha4 | m);
            if (m != 1) begin
                apb(1'b1, `LPC_OFF_CLKSEL, {29'h0, lpc_pkg::CLK_MAIN});
            end
            wake(k + 1);
            check("exit clock", {29'h0, clk_src_sel}, (m == 1) ? 32'h4 : 32'h1);
        end
        for (int i = 0; i < `LPC_NUM_WAKE; i++) begin
            enter(i[0] ? 2'h1 : 2'h0);
            wake(i);
        end
        apb(1'b0, `LPC_OFF_ISR, 32'h0);
        check("isr wake enter", rd & 32'h7, 32'h5);
        apb(1'b1, `LPC_OFF_ISR, 32'h7);
        apb(1'b0, `LPC_OFF_ISR, 32'h0);
        check("isr cleared", rd & 32'h7, 32'h0);
        // wake raised just before entry is taken; the sync delay lands it inside entry
        apb(1'b1, `LPC_OFF_CTRL, 32'h3);
        @(posedge clk);
        wake_src[3] <= 1'b1;
        @(posedge clk);
        cpu_wait_req <= 1'b1;
        @(posedge clk);
        cpu_wait_req <= 1'b0;
        pulse_seen = 1'b0;
        left_normal = 1'b0;
        repeat (14) begin
            @(posedge clk);
            if (irq_exception_req === 1'b1) pulse_seen = 1'b1;
            if (lp_mode !== 2'h0) left_normal = 1'b1;
        end
        check("abort pulse", {31'h0, pulse_seen}, 32'h1);
        check("abort mode", {31'h0, left_normal}, 32'h0);
        wake_src <= '0;
        cycles(8);
        apb(1'b0, `LPC_OFF_ISR, 32'h0);
        check("isr abort", rd & 32'h2, 32'h2);
        apb(1'b1, `LPC_OFF_IMR, 32'h5);
        cycles(2);
        check("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, `LPC_OFF_IMR, 32'h2);
        cycles(2);
        check("irq raised", {31'h0, irq}, 32'h1);
        apb(1'b1, `LPC_OFF_ISR, 32'h2);
        cycles(2);
        check("irq cleared", {31'h0, irq}, 32'h0);
        for (int i = 0; i <= `LPC_NUM_RST; i++) begin
            apb(1'b1, `LPC_OFF_CLKSEL, {29'h0, lpc_pkg::CLK_HOCO});
            if (i < `LPC_NUM_RST) begin
                enter(2'h2);
                reset_src[i] <= 1'b1;
            end else begin
                apb(1'b1, `LPC_OFF_CTRL, 32'h100);
            end
            wait_reset(1'b1);
            check("reset clock", {29'h0, clk_src_sel}, 32'h0);
            check("reset halt", {31'h0, cpu_halt}, 32'h1);
            reset_src <= '0;
            wait_reset(1'b0);
            cycles(2);
            check("post reset mode", {30'h0, lp_mode}, 32'h0);
            check("post reset clock", {29'h0, clk_src_sel}, 32'h0);
        end
        complete_run();
    end
endmodule
`default_nettype wire
